// ===== hw/pcb_pkg.sv
package pcb_pkg;

  // ----------------------------------------------------------------
  // configuration offsets (byte addresses, all but HDR_OFFSET dword aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] TENURE_DW_OFFSET = 8'h0C;  // 0Ch lo half, 0Eh hi half
  localparam logic [7:0] HDR_OFFSET       = 8'h0E;
  localparam logic [7:0] WINDOW_OFFSET    = 8'h10;

  // ----------------------------------------------------------------
  // field positions and fixed values
  // ----------------------------------------------------------------
  localparam int          WIN_BASE_LSB      = 11;
  localparam int          WIN_BASE_W        = 21;
  localparam logic [31:0] WIN_ADDR_MASK     = 32'hFFFF_F800;
  localparam logic [7:0]  SELF_CHECK_VALUE  = 8'h00;
  localparam logic [7:0]  LAYOUT_CODE_VALUE = 8'h00;
  localparam logic [7:0]  TENURE_RESET      = 8'h00;
  localparam logic [7:0]  LINE_BURST_RESET  = 8'h00;
  localparam logic [20:0] WIN_BASE_RESET    = 21'h00_0000;
  localparam logic [7:0]  TENURE_CNT_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcb_cfg_req_t;

  typedef struct packed {
    logic frame_start;
    logic frame_done;
    logic gnt;
  } pcb_mst_t;

  typedef enum logic [1:0] {
    PCB_IDLE    = 2'b00,
    PCB_RUN     = 2'b01,
    PCB_EXPIRED = 2'b10
  } pcb_ten_state_t;

endpackage

// ===== hw/pcb_cfg_regs.sv
`timescale 1ns/1ps
module pcb_cfg_regs (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // configuration access
  input  wire pcb_pkg::pcb_cfg_req_t cfg_req,
  output logic [31:0]               cfg_rdata,
  output logic                      cfg_rvalid,
  // initiator side
  input  wire pcb_pkg::pcb_mst_t    mst,
  output logic                      mst_stop,
  output logic [7:0]                line_burst_length,
  // memory window decode
  input  wire logic [31:0]          mem_addr,
  output logic                      window_hit
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]             tenure_limit_ff;
  logic [7:0]             line_burst_ff;
  logic [20:0]            window_base_upper_ff;
  logic [7:0]             tenure_cnt_ff;
  pcb_pkg::pcb_ten_state_t ten_state_ff;
  logic [31:0]            nxt_rdata;

  function automatic logic is_dw(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  wire wr_hdr = cfg_req.wr && is_dw(cfg_req.addr, pcb_pkg::TENURE_DW_OFFSET);
  wire wr_win = cfg_req.wr && is_dw(cfg_req.addr, pcb_pkg::WINDOW_OFFSET);

  // ----------------------------------------------------------------
  // writable fields, lane by lane
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_burst_ff   <= pcb_pkg::LINE_BURST_RESET;
      tenure_limit_ff <= pcb_pkg::TENURE_RESET;
    end else if (wr_hdr) begin
      if (cfg_req.be[0]) line_burst_ff <= cfg_req.wdata[7:0];
      if (cfg_req.be[1]) tenure_limit_ff <= cfg_req.wdata[15:8];
      // lanes 2-3 hit the read-only 0Eh half and are dropped
    end
  end

  // upper bits only; low lane bits 10-0 have no storage at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_base_upper_ff <= pcb_pkg::WIN_BASE_RESET;
    end else if (wr_win) begin
      if (cfg_req.be[1]) window_base_upper_ff[4:0]   <= cfg_req.wdata[15:11];
      if (cfg_req.be[2]) window_base_upper_ff[12:5]  <= cfg_req.wdata[23:16];
      if (cfg_req.be[3]) window_base_upper_ff[20:13] <= cfg_req.wdata[31:24];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (is_dw(cfg_req.addr, pcb_pkg::TENURE_DW_OFFSET)) begin
      nxt_rdata = {pcb_pkg::SELF_CHECK_VALUE, pcb_pkg::LAYOUT_CODE_VALUE,
                   tenure_limit_ff, line_burst_ff};
    end else if (is_dw(cfg_req.addr, pcb_pkg::WINDOW_OFFSET)) begin
      nxt_rdata = {window_base_upper_ff, 11'h000};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd) cfg_rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // tenure counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ten_state_ff  <= pcb_pkg::PCB_IDLE;
      tenure_cnt_ff <= pcb_pkg::TENURE_CNT_RESET;
    end else if (mst.frame_start) begin
      // a frame may start in the cycle the last one ends; never lose it
      tenure_cnt_ff <= pcb_pkg::TENURE_CNT_RESET;
      ten_state_ff  <= pcb_pkg::PCB_RUN;
    end else begin
      case (ten_state_ff)
        pcb_pkg::PCB_IDLE: begin
          ten_state_ff <= pcb_pkg::PCB_IDLE;
        end
        pcb_pkg::PCB_RUN: begin
          if (mst.frame_done) begin
            ten_state_ff <= pcb_pkg::PCB_IDLE;
          end else if (tenure_cnt_ff + 8'h01 >= tenure_limit_ff) begin
            ten_state_ff <= pcb_pkg::PCB_EXPIRED;
          end else begin
            tenure_cnt_ff <= tenure_cnt_ff + 8'h01;
          end
        end
        pcb_pkg::PCB_EXPIRED: begin
          if (mst.frame_done) ten_state_ff <= pcb_pkg::PCB_IDLE;
        end
        default: ten_state_ff <= pcb_pkg::PCB_IDLE;
      endcase
    end
  end

  // stop only while expired and grant gone; the initiator keeps the bus otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_stop <= 1'b0;
    end else begin
      mst_stop <= (ten_state_ff == pcb_pkg::PCB_EXPIRED) && !mst.gnt
                  && !mst.frame_done && !mst.frame_start;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the rest of the function
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_burst_length <= pcb_pkg::LINE_BURST_RESET;
      window_hit        <= 1'b0;
    end else begin
      line_burst_length <= line_burst_ff;
      window_hit <= (mem_addr & pcb_pkg::WIN_ADDR_MASK)
                    == {window_base_upper_ff, 11'h000};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence all_ones_write_s;
    wr_win && cfg_req.be == 4'hF && cfg_req.wdata == 32'hFFFF_FFFF;
  endsequence

  sequence window_read_s;
    cfg_req.rd && is_dw(cfg_req.addr, pcb_pkg::WINDOW_OFFSET) && !cfg_req.wr;
  endsequence

  size_probe_a: assert property (@(posedge clk) disable iff (!rst_n)
    all_ones_write_s ##1 window_read_s |=> cfg_rdata == 32'hFFFF_F800)
    else $error("size probe readback wrong");

  low_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rvalid && $past(is_dw(cfg_req.addr, pcb_pkg::WINDOW_OFFSET))
    |-> cfg_rdata[10:0] == 11'h000)
    else $error("window low bits not zero");

  hdr_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rvalid && $past(is_dw(cfg_req.addr, pcb_pkg::TENURE_DW_OFFSET))
    |-> cfg_rdata[31:16] == 16'h0000)
    else $error("header half not zero");

  tenure_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_hdr && cfg_req.be[1] |=> tenure_limit_ff == $past(cfg_req.wdata[15:8]))
    else $error("tenure limit not stored");

  lane_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_hdr && !cfg_req.be[0] |=> $stable(line_burst_ff))
    else $error("unenabled lane changed");

  frame_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    mst.frame_start
    |=> tenure_cnt_ff == pcb_pkg::TENURE_CNT_RESET && ten_state_ff == pcb_pkg::PCB_RUN)
    else $error("counter not restarted");

  stop_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    mst_stop |-> $past(ten_state_ff == pcb_pkg::PCB_EXPIRED && !mst.gnt))
    else $error("stop without expiry and grant loss");

  burst_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_hdr && cfg_req.be[0] |-> ##2 line_burst_length == $past(cfg_req.wdata[7:0], 2))
    else $error("burst length not forwarded");

  sequence expired_no_grant_s;
    ten_state_ff == pcb_pkg::PCB_EXPIRED && !mst.gnt && !mst.frame_done && !mst.frame_start;
  endsequence

  stop_on_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
    expired_no_grant_s |=> mst_stop)
    else $error("expired transfer not stopped after grant loss");

  layout_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rvalid && $past(is_dw(cfg_req.addr, pcb_pkg::TENURE_DW_OFFSET))
    |-> cfg_rdata[23:16] == pcb_pkg::LAYOUT_CODE_VALUE)
    else $error("layout code not zero");

  base_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_win && cfg_req.be == 4'hF |=> window_base_upper_ff == $past(cfg_req.wdata[31:11]))
    else $error("window base not stored");

  window_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
    mem_addr[31:11] == window_base_upper_ff |=> window_hit)
    else $error("address inside window not decoded");

  window_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
    mem_addr[31:11] != window_base_upper_ff |=> !window_hit)
    else $error("address outside window decoded");

endmodule

// ===== tb/pcb_host_model.sv
`timescale 1ns/1ps
module pcb_host_model (
  // clock
  input  wire logic                  clk,
  // configuration side
  output pcb_pkg::pcb_cfg_req_t      cfg_req,
  input  wire logic [31:0]           cfg_rdata,
  input  wire logic                  cfg_rvalid,
  // initiator and arbiter side
  output pcb_pkg::pcb_mst_t          mst
);
  // --------------------------------
  // host configuration cycles and initiator frame pulses
  // --------------------------------
  initial begin
    cfg_req = '0;
    mst     = '0;
  end

  // software programs line size and tenure limit through these cycles
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_req.wr    = 1'b1;
    cfg_req.addr  = a;
    cfg_req.be    = be;
    cfg_req.wdata = d;
    @(negedge clk);
    cfg_req.wr    = 1'b0;
    // released data toggles so a stale value never passes for a live one
    cfg_req.wdata = ~d;
  endtask

  // sizing probe: the read follows the write in the very next cycle
  task automatic cfg_wr_rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                           output logic [31:0] q);
    @(negedge clk);
    cfg_req.wr    = 1'b1;
    cfg_req.addr  = a;
    cfg_req.be    = be;
    cfg_req.wdata = d;
    @(negedge clk);
    cfg_req.wr    = 1'b0;
    cfg_req.wdata = ~d;
    cfg_req.rd    = 1'b1;
    @(negedge clk);
    cfg_req.rd    = 1'b0;
    q = cfg_rvalid ? cfg_rdata : 32'hxxxx_xxxx;
  endtask

  // answer comes exactly one edge after the read is taken
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    cfg_req.rd   = 1'b1;
    cfg_req.addr = a;
    @(negedge clk);
    cfg_req.rd   = 1'b0;
    d = cfg_rvalid ? cfg_rdata : 32'hxxxx_xxxx;
  endtask

  task automatic pulse(input logic s, input logic dn);
    @(negedge clk);
    mst.frame_start = s;
    mst.frame_done  = dn;
    @(negedge clk);
    mst.frame_start = 1'b0;
    mst.frame_done  = 1'b0;
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                  clk, rst_n, cfg_rvalid, mst_stop, window_hit;
  logic [31:0]           cfg_rdata, mem_addr, rd;
  logic [7:0]            line_burst_length;
  pcb_pkg::pcb_cfg_req_t cfg_req;
  pcb_pkg::pcb_mst_t     mst;
  int                    fail_count, checks_done;

  pcb_cfg_regs DUT (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .mst(mst), .mst_stop(mst_stop),
    .line_burst_length(line_burst_length), .mem_addr(mem_addr), .window_hit(window_hit));
  pcb_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .mst(mst));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // --------------------------------
  // checking and tests
  // --------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic t_reset;
    host.cfg_rd(8'h0C, rd);
    chk("dw0c", rd, 32'h0000_0000);
    host.cfg_rd(8'h10, rd);
    chk("base", rd, 32'h0000_0000);
    host.cfg_rd(8'h08, rd);
    chk("unmapped", rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_lanes;
    host.cfg_wr(8'h0C, 4'hF, 32'hFFFF_3C05);
    host.cfg_rd(8'h0C, rd);
    chk("dw0c", rd, 32'h0000_3C05);
    chk("burst", {24'h00_0000, line_burst_length}, 32'h0000_0005);
    host.cfg_wr(8'h0E, 4'h2, 32'h0000_AA00);
    host.cfg_rd(8'h0C, rd);
    chk("lane1", rd, 32'h0000_AA05);
    $display("test lanes done");
  endtask

  task automatic t_window;
    host.cfg_wr_rd(8'h10, 4'hF, 32'hFFFF_FFFF, rd);
    chk("probe", rd, 32'hFFFF_F800);
    host.cfg_wr(8'h10, 4'hF, 32'h1234_5FFF);
    host.cfg_rd(8'h10, rd);
    chk("base", rd, 32'h1234_5800);
    mem_addr = 32'h1234_5FFC;
    repeat (2) @(negedge clk);
    chk("hit", {31'h0, window_hit}, 32'h0000_0001);
    mem_addr = 32'h1234_6000;
    repeat (2) @(negedge clk);
    chk("miss", {31'h0, window_hit}, 32'h0000_0000);
    $display("test window done");
  endtask

  task automatic t_tenure;
    host.cfg_wr(8'h0C, 4'h2, 32'h0000_0300);
    host.mst.gnt = 1'b1;
    host.pulse(1'b1, 1'b0);
    repeat (6) @(negedge clk);
    chk("stop_gnt", {31'h0, mst_stop}, 32'h0000_0000);
    host.mst.gnt = 1'b0;
    repeat (2) @(negedge clk);
    chk("stop", {31'h0, mst_stop}, 32'h0000_0001);
    host.pulse(1'b0, 1'b1);
    // a fresh frame must count from zero, not resume the expired count
    host.pulse(1'b1, 1'b0);
    chk("restart", {31'h0, mst_stop}, 32'h0000_0000);
    repeat (3) @(negedge clk);
    chk("early", {31'h0, mst_stop}, 32'h0000_0000);
    @(negedge clk);
    chk("stop2", {31'h0, mst_stop}, 32'h0000_0001);
    host.pulse(1'b0, 1'b1);
    $display("test tenure done");
  endtask

  task automatic t_midreset;
    host.cfg_wr(8'h0C, 4'h3, 32'h0000_2211);
    host.cfg_wr(8'h10, 4'hF, 32'hABCD_E800);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("burst_rst", {24'h00_0000, line_burst_length}, 32'h0000_0000);
    host.cfg_rd(8'h0C, rd);
    chk("dw0c_rst", rd, 32'h0000_0000);
    host.cfg_rd(8'h10, rd);
    chk("base_rst", rd, 32'h0000_0000);
    $display("test midreset done");
  endtask

  initial begin
    fail_count  = 0;
    checks_done = 0;
    rst_n       = 1'b0;
    mem_addr    = 32'h0000_0000;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_lanes;
    t_window;
    t_tenure;
    t_midreset;
    results;
  end

  // whole run is about seventy cycles; this leaves wide margin
  initial begin
    #100_000;
    fail_count++;
    results;
  end
endmodule
